// *** src/cci_capture.sv ***
// Camera capture interface: registers, divider, sync decode, thinning, frame control
`timescale 1ns/1ps
`default_nettype none
// Function
// - Divider field value plus one divides the internal clock for the camera clock.
// - Edge select bit samples data and strobes on rising (0) or falling (1) edge.
// - Format field sets byte order CbYCrY, CrYCbY, YCbYCr or YCrYCb.
// - Line strobe polarity bit: 0 active high, 1 active low.
// - Frame strobe polarity bit: 0 active high, 1 active low.
// - Embedded sync enable decodes BT.656 codes instead of separate strobes.
// - Port select takes camera pins (0) or converter input (1).
// - Interrupt control picks effective frame (0) or capture end (1) as source.
// - Capture end source ignores shutter sync disable and interrupt enable.
// - Single frame mode captures one frame per start command, else repeats.
// - Shutter sync: report frames only during shutter, or always when disabled.
// - Frame sample field thins incoming frames to effective ones.
// - Frames up to 640 by 480 pixels are handled.
// - Module enable starts capture; clearing it ends capture.
// - Fast sampling alternates two sampling circuits each edge.
// - Codes: 0 none, 1..5 keep one in 2..6, 6 and 7 drop all.
// - Interrupt polarity picks frame end (0) or frame start (1).
module cci_capture
    import cci_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire logic [CCI_AW-1:0] addr,
    input wire logic [CCI_DW-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [CCI_DW-1:0] rdata,
    // Camera pins
    input wire logic pixel_clock_in,
    input wire logic [7:0] pixel_byte_in,
    input wire logic frame_valid_in,
    input wire logic line_valid_strobe,
    output logic sensor_clock_out,
    output logic sensor_clock_oe,
    // Converter input
    input wire logic conv_pixel_clock_in,
    input wire logic [7:0] conv_pixel_byte_in,
    input wire logic conv_frame_valid_in,
    input wire logic conv_line_valid_in,
    // Shutter window from the encoder side
    input wire logic shutter_active,
    // Pixel output towards the resizer
    output logic [23:0] pix_data,
    output logic pix_wr,
    output logic pix_line,
    output logic pix_frame,
    output logic frame_irq
);
    cci_smp_if sif ();

    logic [15:0] clkdiv_q;
    logic [15:0] in1_q;
    logic [15:0] in2_q;
    logic [15:0] mode_q;
    logic [15:0] frame_q;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic sclk_q;
    logic sclk_oe_q;
    logic [1:0] pre_q;
    logic vblank_q;
    logic hact_q;
    logic err0_q;
    logic err1_q;
    logic fact_q;
    logic [2:0] fcnt_q;
    logic eff_q;
    logic start_q;
    logic irq_q;
    logic irq_d;
    logic irq_out_q;
    cci_state_t st_q;
    cci_state_t st_d;
    logic [1:0] ph_q;
    logic [7:0] cb_q;
    logic [7:0] cr_q;
    logic [23:0] pix_q;
    logic pix_wr_q;
    logic pix_line_q;
    logic pix_frame_q;
    logic [15:0] rdata_q;

    // Register decode
    wire wr_div = wr_stb && addr == OFS_CLKDIV;
    wire wr_in1 = wr_stb && addr == OFS_IN1;
    wire wr_in2 = wr_stb && addr == OFS_IN2;
    wire wr_mode = wr_stb && addr == OFS_MODE;
    wire wr_frame = wr_stb && addr == OFS_FRAME;
    wire wr_cmd = wr_stb && addr == OFS_CMD;
    wire cmd_srst = wr_cmd && wdata[CMD_SRST];
    wire cmd_clr = wr_cmd && wdata[CMD_IRQCLR];
    wire cmd_start = wr_cmd && wdata[CMD_START];
    wire cmd_stop = wr_cmd && wdata[CMD_STOP];
    wire run = mode_q[MD_EN];

    // Camera clock divider
    wire [4:0] div_n = clkdiv_q[4:0];
    wire [4:0] half = div_n >> 1;
    wire [4:0] fall_at = 5'(half + 5'd1);
    assign cnt_d = (!run || cnt_q == div_n) ? 5'd0 : 5'(cnt_q + 5'd1);
    wire int_rise = run && cnt_q == 5'd0;
    wire int_fall = run && (div_n == 5'd0 || cnt_q == fall_at);

    // Per-port configuration
    wire port = mode_q[MD_PORT];
    wire [1:0] fmt = port ? in2_q[IN_FMT+1:IN_FMT] : in1_q[IN_FMT+1:IN_FMT];
    wire hpol = port ? in2_q[IN_HPOL] : in1_q[IN_HPOL];
    wire vpol = port ? in2_q[IN_VPOL] : in1_q[IN_VPOL];
    wire bt = mode_q[MD_BT656];

    assign sif.port_sel = port;
    assign sif.edge_sel = in1_q[IN_EDGE];
    assign sif.clk_mode = in1_q[IN_CKMODE];
    assign sif.fast = mode_q[MD_FAST];
    assign sif.int_rise = int_rise;
    assign sif.int_fall = int_fall;

    cci_sampler u_smp (
        .clk(clk),
        .arst_n(arst_n),
        .ext_pins({pixel_clock_in, frame_valid_in, line_valid_strobe, pixel_byte_in}),
        .conv_pins({conv_pixel_clock_in, conv_frame_valid_in, conv_line_valid_in,
                    conv_pixel_byte_in}),
        .sif(sif)
    );

    // Embedded sync decode: FF 00 00 then the code byte
    wire vld = sif.valid;
    wire [7:0] d = sif.data;
    wire code = vld && pre_q == 2'd3;
    wire [3:0] prot = {d[5] ^ d[4], d[6] ^ d[4], d[6] ^ d[5], d[6] ^ d[5] ^ d[4]};
    wire prot_bad = code && prot != d[3:0];
    wire head_bad = code && !d[7];
    wire [1:0] pre_d = code ? 2'd0 : (d == SYNC_FF) ? 2'd1 :
                       (pre_q != 2'd0 && d == SYNC_00) ? 2'(pre_q + 2'd1) : 2'd0;
    wire byte_ok = !bt || (pre_q == 2'd0 && d != SYNC_FF);

    // Strobes after polarity or sync decode
    wire hs_act = sif.hs ^ hpol;
    wire vs_act = sif.vs ^ vpol;
    wire line_act = bt ? (hact_q && !vblank_q) : hs_act;
    wire frame_act = bt ? !vblank_q : vs_act;
    wire fstart = vld && frame_act && !fact_q;
    wire fend = vld && !frame_act && fact_q;

    // Frame thinning
    wire [2:0] thin = frame_q[FC_THIN+2:FC_THIN];
    wire thin_cnt = thin != THIN_NONE && thin <= THIN_MAX;
    wire eff = thin == THIN_NONE || (thin_cnt && fcnt_q == 3'd0);
    wire [2:0] fcnt_d = (!thin_cnt || fcnt_q == thin) ? 3'd0 : 3'(fcnt_q + 3'd1);

    // Capture sequencing
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: if (run && start_q) st_d = ST_WAIT;
            ST_WAIT: if (fstart && eff) st_d = ST_CAP;
            ST_CAP: if (fend) st_d = frame_q[FC_SINGLE] ? ST_IDLE : ST_WAIT;
            default: st_d = ST_IDLE;
        endcase
        if (!run || cmd_srst || cmd_stop)
            st_d = ST_IDLE;
    end
    wire cap_end = st_q != ST_IDLE && st_d == ST_IDLE;
    wire single_done = st_q == ST_CAP && fend && frame_q[FC_SINGLE];

    // Interrupt source selection
    wire ev_eff = frame_q[FC_IRQPOL] ? (st_q == ST_WAIT && fstart && eff)
                                     : (st_q == ST_CAP && fend);
    wire shut_ok = frame_q[FC_SSDIS] || shutter_active;
    wire ctl = frame_q[FC_IRQCTL];
    wire irq_set = ctl ? cap_end : (ev_eff && frame_q[FC_IRQEN] && shut_ok);
    assign irq_d = irq_set || (irq_q && !cmd_clr && !cmd_srst);

    // Byte ordering into 4:4:4 pixels
    wire pix_in = vld && byte_ok && line_act && st_q == ST_CAP;
    wire is_y = fmt[1] ? !ph_q[0] : ph_q[0];
    wire is_cr = fmt[0] ^ ph_q[1];

    // Read path
    wire [15:0] stat = {6'h00, err1_q, err0_q, 1'b0, vblank_q, 1'b0, eff_q,
                        st_q == ST_CAP, start_q, irq_q, 1'b0};
    wire [15:0] rd_mux = addr == OFS_CLKDIV ? clkdiv_q :
                         addr == OFS_IN1 ? in1_q :
                         addr == OFS_IN2 ? in2_q :
                         addr == OFS_MODE ? mode_q :
                         addr == OFS_FRAME ? frame_q :
                         addr == OFS_STAT ? stat : RST_REG;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clkdiv_q <= RST_REG;
            in1_q <= RST_REG;
            in2_q <= RST_REG;
            mode_q <= RST_REG;
            frame_q <= RST_REG;
        end
        else
        begin
            if (wr_div) clkdiv_q <= wdata & MASK_CLKDIV;
            if (wr_in1) in1_q <= wdata & MASK_IN1;
            if (wr_in2) in2_q <= wdata & MASK_IN2;
            if (wr_frame) frame_q <= wdata & MASK_FRAME;
            if (wr_mode) mode_q <= wdata & MASK_MODE;
            else if (cmd_srst) mode_q[MD_EN] <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q <= 5'd0;
            sclk_q <= 1'b0;
            sclk_oe_q <= 1'b0;
            rdata_q <= RST_REG;
        end
        else
        begin
            cnt_q <= cnt_d;
            sclk_q <= run && cnt_d <= half;
            sclk_oe_q <= run && !mode_q[MD_CKDIS];
            rdata_q <= rd_stb ? rd_mux : RST_REG;
        end
    end

    // Sync decode, error flags: a new error wins over a clear
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pre_q <= 2'd0;
            vblank_q <= 1'b0;
            hact_q <= 1'b0;
            err0_q <= 1'b0;
            err1_q <= 1'b0;
        end
        else
        begin
            if (vld) pre_q <= pre_d;
            if (code) vblank_q <= d[5];
            if (code) hact_q <= !d[4];
            err0_q <= (bt && prot_bad) || (err0_q && !(wr_cmd && wdata[CMD_ERR0]));
            err1_q <= (bt && head_bad) || (err1_q && !(wr_cmd && wdata[CMD_ERR1]));
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fact_q <= 1'b0;
            fcnt_q <= 3'd0;
            eff_q <= 1'b0;
            st_q <= ST_IDLE;
            start_q <= 1'b1;
            irq_q <= 1'b0;
            irq_out_q <= 1'b0;
        end
        else
        begin
            if (vld) fact_q <= frame_act;
            if (fstart) fcnt_q <= fcnt_d;
            if (fstart) eff_q <= eff;
            st_q <= cmd_srst ? ST_IDLE : st_d;
            if (cmd_srst) start_q <= !cmd_stop;
            else if (cmd_start) start_q <= 1'b1;
            else if (cmd_stop || single_done) start_q <= 1'b0;
            irq_q <= irq_d;
            irq_out_q <= irq_d && (ctl || frame_q[FC_IRQEN]);
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ph_q <= 2'd0;
            cb_q <= 8'h00;
            cr_q <= 8'h00;
            pix_q <= 24'h00_0000;
            pix_wr_q <= 1'b0;
            pix_line_q <= 1'b0;
            pix_frame_q <= 1'b0;
        end
        else
        begin
            if (vld && !line_act) ph_q <= 2'd0;
            else if (pix_in) ph_q <= 2'(ph_q + 2'd1);
            if (pix_in && !is_y && is_cr) cr_q <= d;
            if (pix_in && !is_y && !is_cr) cb_q <= d;
            if (pix_in && is_y) pix_q <= {d, cb_q, cr_q};
            pix_wr_q <= pix_in && is_y;
            pix_line_q <= line_act && st_q == ST_CAP;
            pix_frame_q <= frame_act && st_q == ST_CAP;
        end
    end

    assign rdata = rdata_q;
    assign sensor_clock_out = sclk_q;
    assign sensor_clock_oe = sclk_oe_q;
    assign pix_data = pix_q;
    assign pix_wr = pix_wr_q;
    assign pix_line = pix_line_q;
    assign pix_frame = pix_frame_q;
    assign frame_irq = irq_out_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    property p_div_wrap;
        (run && cnt_q == div_n) |=> cnt_q == 5'd0;
    endproperty
    a_div_wrap: assert property (p_div_wrap) else $error("divider did not wrap");
    property p_hpol;
        (!bt && vld) |-> line_act == (sif.hs ^ hpol);
    endproperty
    a_hpol: assert property (p_hpol) else $error("line strobe polarity wrong");
    property p_end_irq;
        (ctl && cap_end) |=> irq_q ##1 frame_irq;
    endproperty
    a_end_irq: assert property (p_end_irq) else $error("capture end interrupt missing");
    property p_single;
        (single_done && !cmd_start && !cmd_srst) |=> (!start_q && st_q == ST_IDLE);
    endproperty
    a_single: assert property (p_single) else $error("single frame did not stop");
    property p_clk_off;
        mode_q[MD_CKDIS] |=> !sensor_clock_oe;
    endproperty
    a_clk_off: assert property (p_clk_off) else $error("clock pin still driven");
    property p_disable;
        !run |=> st_q == ST_IDLE;
    endproperty
    a_disable: assert property (p_disable) else $error("capture active while disabled");
    property p_drop_all;
        (st_q == ST_WAIT && thin > THIN_MAX) |=> st_q != ST_CAP;
    endproperty
    a_drop_all: assert property (p_drop_all) else $error("thinned frame captured");
    c_capture: cover property (st_q == ST_WAIT ##1 st_q == ST_CAP);
    c_irq: cover property (!ctl && $rose(irq_q));
    c_bt_code: cover property (bt && code);
endmodule : cci_capture
`default_nettype wire

// *** src/cci_pkg.sv ***
// Constants, register map and types of the camera capture interface
package cci_pkg;
    localparam int CCI_AW = 8;
    localparam int CCI_DW = 16;
    // Register offsets
    localparam logic [7:0] OFS_CLKDIV = 8'h00;
    localparam logic [7:0] OFS_IN1 = 8'h04;
    localparam logic [7:0] OFS_IN2 = 8'h0c;
    localparam logic [7:0] OFS_MODE = 8'h20;
    localparam logic [7:0] OFS_FRAME = 8'h24;
    localparam logic [7:0] OFS_CMD = 8'h28;
    localparam logic [7:0] OFS_STAT = 8'h2c;
    // Reset values and writable bits
    localparam logic [15:0] RST_REG = 16'h0000;
    localparam logic [15:0] RST_STAT = 16'h0004;
    localparam logic [15:0] MASK_CLKDIV = 16'h001f;
    localparam logic [15:0] MASK_IN1 = 16'h003f;
    localparam logic [15:0] MASK_IN2 = 16'h001e;
    localparam logic [15:0] MASK_MODE = 16'h0499;
    localparam logic [15:0] MASK_FRAME = 16'h01ff;
    // Input signal setup fields
    localparam int IN_EDGE = 0;
    localparam int IN_VPOL = 1;
    localparam int IN_HPOL = 2;
    localparam int IN_FMT = 3;
    localparam int IN_CKMODE = 5;
    // Capture mode fields
    localparam int MD_EN = 0;
    localparam int MD_CKDIS = 3;
    localparam int MD_PORT = 4;
    localparam int MD_BT656 = 7;
    localparam int MD_FAST = 10;
    // Frame control fields
    localparam int FC_IRQEN = 0;
    localparam int FC_IRQPOL = 1;
    localparam int FC_THIN = 2;
    localparam int FC_SSDIS = 5;
    localparam int FC_SINGLE = 6;
    localparam int FC_IRQCTL = 7;
    // Command bits
    localparam int CMD_SRST = 0;
    localparam int CMD_IRQCLR = 1;
    localparam int CMD_START = 2;
    localparam int CMD_STOP = 3;
    localparam int CMD_ERR0 = 8;
    localparam int CMD_ERR1 = 9;
    // Thinning codes and sync pattern
    localparam logic [2:0] THIN_NONE = 3'h0;
    localparam logic [2:0] THIN_MAX = 3'h5;
    localparam logic [7:0] SYNC_FF = 8'hff;
    localparam logic [7:0] SYNC_00 = 8'h00;
    // Pin bundle layout: {pixel clock, frame strobe, line strobe, data}
    localparam int PIN_W = 11;
    localparam int PIN_CLK = 10;
    localparam int PIN_VS = 9;
    localparam int PIN_HS = 8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_CAP = 2'b11
    } cci_state_t;
endpackage : cci_pkg

// *** src/cci_smp_if.sv ***
// Bundle between the capture core and its pin sampler
`timescale 1ns/1ps
`default_nettype none
interface cci_smp_if;
    logic port_sel;
    logic edge_sel;
    logic clk_mode;
    logic fast;
    logic int_rise;
    logic int_fall;
    logic valid;
    logic [7:0] data;
    logic hs;
    logic vs;
    modport core (output port_sel, edge_sel, clk_mode, fast, int_rise, int_fall,
                  input valid, data, hs, vs);
    modport smp (input port_sel, edge_sel, clk_mode, fast, int_rise, int_fall,
                 output valid, data, hs, vs);
endinterface : cci_smp_if
`default_nettype wire

// *** src/cci_sampler.sv ***
// Pin synchroniser, clock edge finder and sample banks
`timescale 1ns/1ps
`default_nettype none
module cci_sampler
    import cci_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Raw pins of both sources
    input wire logic [PIN_W-1:0] ext_pins,
    input wire logic [PIN_W-1:0] conv_pins,
    // Core side
    cci_smp_if.smp sif
);
    logic [2*PIN_W-1:0] s1_q;
    logic [2*PIN_W-1:0] s2_q;
    logic [2*PIN_W-1:0] s3_q;
    logic bank_q;
    logic [PIN_W-2:0] bank_a_q;
    logic [PIN_W-2:0] bank_b_q;
    logic valid_q;
    logic [PIN_W-2:0] out_q;

    wire [PIN_W-1:0] cur = sif.port_sel ? s2_q[2*PIN_W-1:PIN_W] : s2_q[PIN_W-1:0];
    wire [PIN_W-1:0] old = sif.port_sel ? s3_q[2*PIN_W-1:PIN_W] : s3_q[PIN_W-1:0];
    wire ext_rise = cur[PIN_CLK] & ~old[PIN_CLK];
    wire ext_fall = ~cur[PIN_CLK] & old[PIN_CLK];
    wire int_hit = sif.edge_sel ? sif.int_fall : sif.int_rise;
    wire ext_hit = sif.edge_sel ? ext_fall : ext_rise;
    wire hit = sif.clk_mode ? int_hit : ext_hit;
    wire [PIN_W-2:0] src = old[PIN_W-2:0];
    wire [PIN_W-2:0] fresh = bank_q ? bank_a_q : bank_b_q;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= {conv_pins, ext_pins};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Fast mode loads two banks in turn, so each bank holds a sample for two edges
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bank_q <= 1'b0;
            bank_a_q <= '0;
            bank_b_q <= '0;
            valid_q <= 1'b0;
            out_q <= '0;
        end
        else
        begin
            valid_q <= hit;
            if (hit && sif.fast)
                bank_q <= ~bank_q;
            if (hit && sif.fast && !bank_q)
                bank_a_q <= src;
            if (hit && sif.fast && bank_q)
                bank_b_q <= src;
            if (hit && !sif.fast)
                out_q <= src;
        end
    end

    assign sif.valid = valid_q;
    assign sif.data = sif.fast ? fresh[7:0] : out_q[7:0];
    assign sif.hs = sif.fast ? fresh[PIN_HS] : out_q[PIN_HS];
    assign sif.vs = sif.fast ? fresh[PIN_VS] : out_q[PIN_VS];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    property p_edge_sample;
        (!sif.clk_mode && !sif.edge_sel && ext_rise) |=> valid_q;
    endproperty
    a_edge_sample: assert property (p_edge_sample) else $error("rising edge not sampled");
    c_fall_sample: cover property (sif.edge_sel && ext_fall ##1 valid_q);
endmodule : cci_sampler
`default_nettype wire

// *** bench/cci_cam_model.sv ***
// Camera side model: one frame of one eight-byte line per go pulse
`timescale 1ns/1ps
`default_nettype none
module cci_cam_model (
    // Bench control
    input wire logic go,
    input wire logic fe,
    input wire logic hpol,
    input wire logic vpol,
    input wire logic [7:0] seed,
    // Camera pins
    output logic pclk,
    output logic [7:0] data,
    output logic vs,
    output logic hs,
    output logic busy
);
    initial
    begin
        pclk = 1'b0;
        data = 8'h00;
        {hs, vs} = 2'b00;
        busy = 1'b0;
    end
    // Strobes rest at their inactive level between frames
    always @*
        if (busy !== 1'b1)
            {hs, vs} = {hpol, vpol};
    // Pins change on the edge opposite the sampling one
    task automatic tick(input logic [7:0] d, input logic h, input logic v);
        pclk = 1'b1;
        if (fe)
            {data, hs, vs} = {d, h, v};
        #62;
        pclk = 1'b0;
        if (!fe)
            {data, hs, vs} = {d, h, v};
        #63;
    endtask : tick
    always @(posedge go)
    begin
        busy = 1'b1;
        repeat (2) tick(~data, hpol, ~vpol);
        for (int i = 0; i < 8; i++)
            tick(seed + 8'(i * 17), ~hpol, ~vpol);
        repeat (2) tick(~data, hpol, ~vpol);
        repeat (2) tick(~data, hpol, vpol);
        busy = 1'b0;
    end
endmodule : cci_cam_model
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench of the camera capture interface
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cci_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, shutter_active = 1'b0;
    logic [7:0] addr = 8'h00, seed = 8'h00, pixel_byte_in, conv_pixel_byte_in;
    logic [15:0] wdata = 16'h0000, rdata;
    logic pixel_clock_in, frame_valid_in, line_valid_strobe, sensor_clock_out, sensor_clock_oe;
    logic conv_pixel_clock_in, conv_frame_valid_in, conv_line_valid_in;
    logic [23:0] pix_data;
    logic pix_wr, pix_line, pix_frame, frame_irq, fe = 1'b0, hpol = 1'b0, vpol = 1'b0;
    logic [1:0] go = 2'b00, busy;
    logic [23:0] pq[$];
    logic [7:0] ofs[8] = '{OFS_CLKDIV, OFS_IN1, OFS_IN2, OFS_MODE, OFS_FRAME, OFS_CMD, 8'h08,
        OFS_STAT};
    logic [7:0] rw[5] = '{OFS_CLKDIV, OFS_IN1, OFS_IN2, OFS_MODE, OFS_FRAME};
    logic [15:0] msk[5] = '{MASK_CLKDIV, MASK_IN1, MASK_IN2, MASK_MODE, MASK_FRAME};
    int bad_count = 0, n_compared = 0, sv = 32'h7285bf67;
    always #2.5 clk = ~clk;
    always @(posedge clk)
        if (pix_wr === 1'b1)
        begin
            pq.push_back(pix_data);
            check({30'h0, pix_line, pix_frame}, 32'h3);
        end
    cci_capture DUT (.clk, .arst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
        .pixel_clock_in, .pixel_byte_in, .frame_valid_in, .line_valid_strobe,
        .sensor_clock_out, .sensor_clock_oe, .conv_pixel_clock_in, .conv_pixel_byte_in,
        .conv_frame_valid_in, .conv_line_valid_in, .shutter_active, .pix_data, .pix_wr,
        .pix_line, .pix_frame, .frame_irq);
    cci_cam_model u_cam (.go(go[0]), .fe, .hpol, .vpol, .seed, .pclk(pixel_clock_in),
        .data(pixel_byte_in), .vs(frame_valid_in), .hs(line_valid_strobe), .busy(busy[0]));
    cci_cam_model u_conv (.go(go[1]), .fe, .hpol, .vpol, .seed, .pclk(conv_pixel_clock_in),
        .data(conv_pixel_byte_in), .vs(conv_frame_valid_in), .hs(conv_line_valid_in),
        .busy(busy[1]));
    task automatic end_of_test;
        if (bad_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 check({16'h0, rdata}, {16'h0, e});
    endtask : rdc
    task automatic launch(input int w);
        @(posedge clk);
        seed <= 8'($random(sv));
        go[w] <= 1'b1;
        @(posedge clk);
        go <= 2'b00;
    endtask : launch
    task automatic settle;
        int k;
        for (k = 0; k < 3000 && busy !== 2'b00; k++)
            @(posedge clk);
        if (k == 3000)
        begin
            bad_count++;
            end_of_test;
        end
        repeat (20) @(posedge clk);
    endtask : settle
    task automatic frm(input int w);
        launch(w);
        settle;
    endtask : frm
    task automatic pix_cnt(input logic [31:0] e);
        check(32'(pq.size()), e);
        pq.delete();
    endtask : pix_cnt
    task automatic irq_is(input logic e);
        check({31'h0, frame_irq}, {31'h0, e});
    endtask : irq_is
    // Expected {Y, Cb, Cr} per Y byte once both chroma bytes of the line are known
    task automatic chk_line(input logic [1:0] f);
        logic [7:0] b, cb, cr;
        int n, p;
        bit vb, vr;
        n = 0;
        vb = 0;
        vr = 0;
        check(32'(pq.size()), 32'd4);
        for (int j = 0; j < 8; j++)
        begin
            b = seed + 8'(j * 17);
            p = j % 4;
            if (p[0] != f[1])
            begin
                if (vb && vr && n < pq.size())
                    check({8'h0, pq[n]}, {8'h0, b, cb, cr});
                n++;
            end
            else if (f[0] ^ (p >= 2))
                {cr, vr} = {b, 1'b1};
            else
                {cb, vb} = {b, 1'b1};
        end
        pq.delete();
    endtask : chk_line
    task automatic div_chk(input logic [4:0] d);
        int r;
        logic p;
        wr(OFS_CLKDIV, {11'h0, d});
        repeat (36) @(posedge clk);
        #1 p = sensor_clock_out;
        r = 0;
        repeat (8 * (d + 1))
        begin
            @(posedge clk);
            #1 r += (sensor_clock_out === 1'b1 && p === 1'b0);
            p = sensor_clock_out;
        end
        check(32'(r), 32'd8);
    endtask : div_chk
    initial
    begin
        logic [15:0] r;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        foreach (ofs[i])
            rdc(ofs[i], ofs[i] == OFS_STAT ? RST_STAT : RST_REG);
        repeat (4)
            foreach (rw[i])
            begin
                r = 16'($random(sv)) & 16'hfefe;
                wr(rw[i], r);
                rdc(rw[i], r & msk[i]);
            end
        wr(8'h08, 16'hffff);
        rdc(8'h08, 16'h0000);
        foreach (rw[i])
            wr(rw[i], 16'h0000);
        wr(OFS_MODE, 16'h0001);
        div_chk(5'h01);
        div_chk(5'h02);
        div_chk(5'h1f);
        div_chk(5'($random(sv)) | 5'h01);
        irq_is(1'b0);
        check({31'h0, sensor_clock_oe}, 32'h1);
        wr(OFS_MODE, 16'h0009);
        repeat (3) @(posedge clk);
        check({31'h0, sensor_clock_oe}, 32'h0);
        wr(OFS_MODE, 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            r = 16'($random(sv));
            fe <= i[2];
            hpol <= r[0];
            vpol <= r[1];
            wr(OFS_IN1, {10'h0, 1'b0, i[1:0], r[0], r[1], i[2]});
            wr(OFS_MODE, {5'h0, r[2], 10'h001});
            frm(0);
            chk_line(i[1:0]);
            wr(OFS_MODE, 16'h0000);
        end
        {fe, hpol, vpol} <= 3'b000;
        wr(OFS_IN1, 16'h0000);
        for (int c = 0; c < 8; c++)
        begin
            wr(OFS_FRAME, 16'(c << 2));
            wr(OFS_MODE, 16'h0001);
            repeat (c == 0 ? 2 : c < 6 ? 2 * (c + 1) : 3) frm(0);
            pix_cnt(c < 6 ? 32'd8 : 32'd0);
            wr(OFS_MODE, 16'h0000);
        end
        for (int p = 0; p < 2; p++)
        begin
            wr(OFS_FRAME, 16'(16'h0021 | p << 1));
            wr(OFS_MODE, 16'h0001);
            launch(0);
            repeat (150) @(posedge clk);
            irq_is(p[0]);
            settle;
            irq_is(1'b1);
            wr(OFS_CMD, 16'h0002);
            wr(OFS_MODE, 16'h0000);
            irq_is(1'b0);
        end
        wr(OFS_FRAME, 16'h0020);
        wr(OFS_MODE, 16'h0001);
        frm(0);
        irq_is(1'b0);
        wr(OFS_FRAME, 16'h0001);
        frm(0);
        irq_is(1'b0);
        shutter_active <= 1'b1;
        frm(0);
        irq_is(1'b1);
        wr(OFS_CMD, 16'h0002);
        wr(OFS_MODE, 16'h0000);
        shutter_active <= 1'b0;
        wr(OFS_FRAME, 16'h0080);
        wr(OFS_MODE, 16'h0001);
        frm(0);
        irq_is(1'b0);
        wr(OFS_MODE, 16'h0000);
        repeat (3) @(posedge clk);
        irq_is(1'b1);
        wr(OFS_CMD, 16'h0002);
        pq.delete();
        wr(OFS_FRAME, 16'h0040);
        wr(OFS_CMD, 16'h0004);
        wr(OFS_MODE, 16'h0001);
        repeat (2) frm(0);
        pix_cnt(32'd4);
        wr(OFS_CMD, 16'h0004);
        wr(OFS_MODE, 16'h0000);
        frm(0);
        pix_cnt(32'd0);
        wr(OFS_FRAME, 16'h0000);
        wr(OFS_MODE, 16'h0011);
        frm(0);
        pix_cnt(32'd0);
        frm(1);
        chk_line(2'b00);
        end_of_test;
    end
endmodule : tb
`default_nettype wire
